// file: rtc_pkg.sv
// Purpose: Shared constants for the BCD real time clock with alarm and tick
// Assumes: Byte-wide registers, one per aligned word, on a plain strobe port
// Notes:   Time and alarm fields are packed BCD, reserved bits read as zero
package rtc_pkg;

   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 8;

   // Register byte addresses
   localparam logic [7:0]  OFS_CTRL       = 8'h40;
   localparam logic [7:0]  OFS_TICK       = 8'h44;
   localparam logic [7:0]  OFS_ALM_CTRL   = 8'h50;
   localparam logic [7:0]  OFS_ALM_BASE   = 8'h54;
   localparam logic [7:0]  OFS_TIME_BASE  = 8'h70;
   localparam logic [7:0]  OFS_IRQ_STS    = 8'h90;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h94;
   localparam logic [2:0]  ALM_FIELDS     = 3'h6;
   localparam logic [2:0]  TIME_FIELDS    = 3'h7;

   // Time field indices
   localparam logic [2:0]  T_SEC          = 3'h0;
   localparam logic [2:0]  T_MIN          = 3'h1;
   localparam logic [2:0]  T_HOUR         = 3'h2;
   localparam logic [2:0]  T_DATE         = 3'h3;
   localparam logic [2:0]  T_DAY          = 3'h4;
   localparam logic [2:0]  T_MON          = 3'h5;
   localparam logic [2:0]  T_YEAR         = 3'h6;

   // Control, tick and alarm control bits
   localparam int          CTRL_ACCESS    = 0;
   localparam int          CTRL_CNT_RST   = 3;
   localparam int          CTRL_W         = 4;
   localparam int          TICK_EN        = 7;
   localparam int          TICK_CNT_W     = 7;
   localparam int          ALM_GLOBAL     = 6;
   localparam int          ALM_CTRL_W     = 7;
   localparam int          IRQ_ALARM      = 0;
   localparam int          IRQ_TICK       = 1;
   localparam int          IRQ_W          = 2;

   // Crystal division: 32.768 kHz to 128 Hz to 1 Hz
   localparam int          XTAL_HZ        = 32768;
   localparam int          TICK_HZ        = 128;
   localparam int          PRE_DIV        = XTAL_HZ / TICK_HZ;
   localparam logic [7:0]  PRE_LAST       = 8'(PRE_DIV - 1);
   localparam logic [6:0]  SUB_LAST       = 7'(TICK_HZ - 1);

   // BCD limits and reset values
   localparam logic [3:0]  BCD_NINE       = 4'h9;
   localparam logic [7:0]  BCD_ZERO       = 8'h00;
   localparam logic [7:0]  BCD_ONE        = 8'h01;
   localparam logic [7:0]  SEC_MAX        = 8'h59;
   localparam logic [7:0]  HOUR_MAX       = 8'h23;
   localparam logic [7:0]  DAY_MAX        = 8'h07;
   localparam logic [7:0]  MON_MAX        = 8'h12;
   localparam logic [7:0]  YEAR_MAX       = 8'h99;
   localparam logic [7:0]  MON_FEB        = 8'h02;
   localparam logic [7:0]  LAST_28        = 8'h28;
   localparam logic [7:0]  LAST_29        = 8'h29;
   localparam logic [7:0]  LAST_30        = 8'h30;
   localparam logic [7:0]  LAST_31        = 8'h31;
   localparam logic [7:0]  MASK_SEC       = 8'h7f;
   localparam logic [7:0]  MASK_HOUR      = 8'h3f;
   localparam logic [7:0]  MASK_DAY       = 8'h07;
   localparam logic [7:0]  MASK_MON       = 8'h1f;
   localparam logic [7:0]  MASK_YEAR      = 8'hff;

endpackage : rtc_pkg

// file: bcd_rtc_alarm_tick.sv
// Purpose: BCD calendar clock with alarm, wake-up and periodic tick interrupt
// Assumes: xtal_in is a 32.768 kHz level sampled on core_clk (20 MHz)
// Notes:   power_off isolates the register port; counting carries on
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Seconds, minutes, hours, date, day, month and year are BCD counters read as bytes.
// - All timekeeping is divided down from the 32.768 kHz crystal.
// - The last date of a month is 28, 29, 30 or 31 by month and leap year.
// - Year 00 counts as 2000 and is therefore a leap year.
// - Time registers accept writes only while the access enable bit is one.
// - During power off the register port is cut off while the counters keep running.
// - In normal operation the alarm raises the alarm interrupt when the time matches.
// - In power-off mode the alarm also drives the wake-up output.
// - The tick count runs down and requests a tick interrupt when it reaches zero.
// - The tick period is (n+1)/128 second for programmed count n.
// - Tick control holds the enable in bit 7 and the count in bits 6:0, counter unreadable.
module bcd_rtc_alarm_tick
(
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   input  wire logic                       xtal_in,
   input  wire logic                       power_off,
   input  wire logic [rtc_pkg::ADDR_W-1:0] addr,
   input  wire logic [rtc_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr_en,
   input  wire logic                       rd_en,
   output logic      [rtc_pkg::DATA_W-1:0] rdata,
   output logic                            irq_out,
   output logic                            power_wakeup_out
);

   typedef struct packed {
      logic                              xtal_prev;
      logic [7:0]                        pre;
      logic [6:0]                        sub;
      logic [rtc_pkg::TICK_CNT_W-1:0]    tick_cnt;
      logic [rtc_pkg::CTRL_W-1:0]        clock_control_reg;
      logic [7:0]                        tick_control_reg;
      logic [rtc_pkg::ALM_CTRL_W-1:0]    alarm_control_reg;
      logic [6:0][7:0]                   time_bcd;
      logic [5:0][7:0]                   alm_bcd;
      logic [rtc_pkg::IRQ_W-1:0]         irq_sts;
      logic [rtc_pkg::IRQ_W-1:0]         irq_mask;
      logic                              match;
      logic                              irq;
      logic                              wake;
      logic [7:0]                        rdata;
   } state_t;

   state_t                          s_q;
   state_t                          s_d;
   logic                            xtal_edge;
   logic                            tick128;
   logic                            sec_tick;
   logic                            match_now;
   logic                            alm_event;
   logic                            wr_ok;
   logic                            rd_ok;
   logic [rtc_pkg::IRQ_W-1:0]       irq_set;
   logic [rtc_pkg::IRQ_W-1:0]       irq_clr;
   logic [8:0]                      inc;
   logic                            carry;
   logic [3:0]                      hit_t;
   logic [3:0]                      hit_a;
   logic [2:0]                      ti;
   localparam int                   TICK_CNT_HI = rtc_pkg::TICK_CNT_W - 1;

   // Word-aligned window decode, returns {hit, index}
   function automatic logic [3:0] region_idx(input logic [7:0] a, input logic [7:0] base,
                                             input logic [2:0] count);
      logic [7:0] off;
      logic       hit;
      off = a - base;
      hit = (a >= base) && (off[1:0] == 2'h0) && (off[7:2] < {3'h0, count});
      return {hit, off[4:2]};
   endfunction : region_idx

   // Alarm fields skip the day-of-week counter
   function automatic logic [2:0] alm_to_time(input logic [2:0] i);
      return (i < rtc_pkg::T_DAY) ? i : 3'(i + 3'h1);
   endfunction : alm_to_time

   function automatic logic [7:0] field_mask(input logic [2:0] t);
      case (t)
         rtc_pkg::T_SEC, rtc_pkg::T_MIN: return rtc_pkg::MASK_SEC;
         rtc_pkg::T_HOUR, rtc_pkg::T_DATE: return rtc_pkg::MASK_HOUR;
         rtc_pkg::T_DAY: return rtc_pkg::MASK_DAY;
         rtc_pkg::T_MON: return rtc_pkg::MASK_MON;
         default: return rtc_pkg::MASK_YEAR;
      endcase
   endfunction : field_mask

   // BCD increment with wrap, returns {wrapped, value}
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
      // Using >= also recovers from out-of-range values written by software
      if (v >= hi)
         return {1'b1, lo};
      else if (v[3:0] >= rtc_pkg::BCD_NINE)
         return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
      else
         return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
   endfunction : bcd_inc

   // Divisible by four in BCD; 00 is taken as 2000
   function automatic logic is_leap(input logic [7:0] y);
      if (!y[4])
         return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      else
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
   endfunction : is_leap

   function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
      case (m)
         rtc_pkg::MON_FEB: return is_leap(y) ? rtc_pkg::LAST_29 : rtc_pkg::LAST_28;
         8'h04, 8'h06, 8'h09, 8'h11: return rtc_pkg::LAST_30;
         default: return rtc_pkg::LAST_31;
      endcase
   endfunction : last_date

   always_comb
   begin
      s_d       = s_q;
      irq_set   = '0;
      irq_clr   = '0;
      inc       = '0;
      carry     = 1'b0;
      ti        = '0;
      wr_ok     = wr_en && !power_off;
      rd_ok     = rd_en && !power_off;
      hit_t     = region_idx(addr, rtc_pkg::OFS_TIME_BASE, rtc_pkg::TIME_FIELDS);
      hit_a     = region_idx(addr, rtc_pkg::OFS_ALM_BASE, rtc_pkg::ALM_FIELDS);

      // Prescaler: crystal edges to 128 Hz, then to 1 Hz
      s_d.xtal_prev = xtal_in;
      xtal_edge = xtal_in && !s_q.xtal_prev;
      tick128   = 1'b0;
      if (s_q.clock_control_reg[rtc_pkg::CTRL_CNT_RST])
      begin
         s_d.pre = '0;
         s_d.sub = '0;
      end
      else if (xtal_edge)
      begin
         s_d.pre = 8'(s_q.pre + 8'h01);
         tick128 = (s_q.pre == rtc_pkg::PRE_LAST);
         if (tick128)
            s_d.sub = 7'(s_q.sub + 7'h01);
      end
      sec_tick = tick128 && (s_q.sub == rtc_pkg::SUB_LAST);

      // Calendar cascade, one carry per stage
      if (sec_tick)
      begin
         inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_SEC], rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
         s_d.time_bcd[rtc_pkg::T_SEC] = inc[7:0];
         carry = inc[8];
         if (carry)
         begin
            inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_MIN], rtc_pkg::BCD_ZERO, rtc_pkg::SEC_MAX);
            s_d.time_bcd[rtc_pkg::T_MIN] = inc[7:0];
            carry = inc[8];
         end
         if (carry)
         begin
            inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_HOUR], rtc_pkg::BCD_ZERO, rtc_pkg::HOUR_MAX);
            s_d.time_bcd[rtc_pkg::T_HOUR] = inc[7:0];
            carry = inc[8];
         end
         if (carry)
         begin
            inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_DAY], rtc_pkg::BCD_ONE, rtc_pkg::DAY_MAX);
            s_d.time_bcd[rtc_pkg::T_DAY] = inc[7:0];
            inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_DATE], rtc_pkg::BCD_ONE,
                          last_date(s_q.time_bcd[rtc_pkg::T_MON],
                                    s_q.time_bcd[rtc_pkg::T_YEAR]));
            s_d.time_bcd[rtc_pkg::T_DATE] = inc[7:0];
            carry = inc[8];
         end
         if (carry)
         begin
            inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_MON], rtc_pkg::BCD_ONE, rtc_pkg::MON_MAX);
            s_d.time_bcd[rtc_pkg::T_MON] = inc[7:0];
            carry = inc[8];
         end
         if (carry)
         begin
            inc = bcd_inc(s_q.time_bcd[rtc_pkg::T_YEAR], rtc_pkg::BCD_ZERO, rtc_pkg::YEAR_MAX);
            s_d.time_bcd[rtc_pkg::T_YEAR] = inc[7:0];
         end
      end

      // Tick down-counter, reload on zero gives n+1 steps per period
      if (tick128)
      begin
         if (s_q.tick_cnt == '0)
         begin
            s_d.tick_cnt = s_q.tick_control_reg[TICK_CNT_HI:0];
            irq_set[rtc_pkg::IRQ_TICK] = s_q.tick_control_reg[rtc_pkg::TICK_EN];
         end
         else
            s_d.tick_cnt = 7'(s_q.tick_cnt - 7'h01);
      end

      // Alarm compare, edge of the match so a held match fires once
      match_now = s_q.alarm_control_reg[rtc_pkg::ALM_GLOBAL];
      for (int i = 0; i < 6; i++)
      begin
         ti = alm_to_time(3'(i));
         if (s_q.alarm_control_reg[i] && (s_q.time_bcd[ti] != s_q.alm_bcd[i]))
            match_now = 1'b0;
      end
      s_d.match = match_now;
      alm_event = match_now && !s_q.match;
      irq_set[rtc_pkg::IRQ_ALARM] = alm_event;

      // Register writes; a time write beats the carry in the same cycle
      if (wr_ok)
      begin
         case (addr)
            rtc_pkg::OFS_CTRL: s_d.clock_control_reg = wdata[rtc_pkg::CTRL_W-1:0];
            rtc_pkg::OFS_TICK:
            begin
               s_d.tick_control_reg = wdata;
               s_d.tick_cnt = wdata[TICK_CNT_HI:0];
            end
            rtc_pkg::OFS_ALM_CTRL: s_d.alarm_control_reg = wdata[rtc_pkg::ALM_CTRL_W-1:0];
            rtc_pkg::OFS_IRQ_STS: irq_clr = wdata[rtc_pkg::IRQ_W-1:0];
            rtc_pkg::OFS_IRQ_MASK: s_d.irq_mask = wdata[rtc_pkg::IRQ_W-1:0];
            default:
            begin
               if (hit_a[3])
                  s_d.alm_bcd[hit_a[2:0]] = wdata & field_mask(alm_to_time(hit_a[2:0]));
               if (hit_t[3] && s_q.clock_control_reg[rtc_pkg::CTRL_ACCESS])
                  s_d.time_bcd[hit_t[2:0]] = wdata & field_mask(hit_t[2:0]);
            end
         endcase
      end

      // Sticky status: a new event wins over a clear in the same cycle
      s_d.irq_sts = (s_q.irq_sts & ~irq_clr) | irq_set;
      s_d.irq     = |(s_d.irq_sts & s_d.irq_mask);

      // Wake-up only while powered off, dropped when power returns
      if (!power_off)
         s_d.wake = 1'b0;
      else if (alm_event)
         s_d.wake = 1'b1;

      // Read data valid the cycle after the strobe, zero otherwise
      s_d.rdata = '0;
      if (rd_ok)
      begin
         case (addr)
            rtc_pkg::OFS_CTRL: s_d.rdata = {4'h0, s_q.clock_control_reg};
            rtc_pkg::OFS_TICK: s_d.rdata = s_q.tick_control_reg;
            rtc_pkg::OFS_ALM_CTRL: s_d.rdata = {1'b0, s_q.alarm_control_reg};
            rtc_pkg::OFS_IRQ_STS: s_d.rdata = {6'h00, s_q.irq_sts};
            rtc_pkg::OFS_IRQ_MASK: s_d.rdata = {6'h00, s_q.irq_mask};
            default:
            begin
               if (hit_a[3])
                  s_d.rdata = s_q.alm_bcd[hit_a[2:0]];
               else if (hit_t[3])
                  s_d.rdata = s_q.time_bcd[hit_t[2:0]];
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q                             <= '0;
         s_q.time_bcd[rtc_pkg::T_DATE]   <= rtc_pkg::BCD_ONE;
         s_q.time_bcd[rtc_pkg::T_DAY]    <= rtc_pkg::BCD_ONE;
         s_q.time_bcd[rtc_pkg::T_MON]    <= rtc_pkg::BCD_ONE;
         s_q.alm_bcd[3]                  <= rtc_pkg::BCD_ONE;
         s_q.alm_bcd[4]                  <= rtc_pkg::BCD_ONE;
      end
      else
         s_q <= s_d;
   end

   assign rdata            = s_q.rdata;
   assign irq_out          = s_q.irq;
   assign power_wakeup_out = s_q.wake;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_locked_write: assert property (
      wr_en && !power_off && !sec_tick && !s_q.clock_control_reg[rtc_pkg::CTRL_ACCESS]
      && (addr == rtc_pkg::OFS_TIME_BASE)
      |=> s_q.time_bcd[rtc_pkg::T_SEC] == $past(s_q.time_bcd[rtc_pkg::T_SEC]))
      else $error("time write accepted while access disabled");
   chk_open_write: assert property (
      wr_en && !power_off && s_q.clock_control_reg[rtc_pkg::CTRL_ACCESS]
      && (addr == rtc_pkg::OFS_TIME_BASE + 8'h18)
      |=> s_q.time_bcd[rtc_pkg::T_YEAR] == $past(wdata))
      else $error("enabled year write not stored");
   chk_sec_wrap: assert property (
      sec_tick && !wr_en && (s_q.time_bcd[rtc_pkg::T_SEC] == rtc_pkg::SEC_MAX)
      |=> (s_q.time_bcd[rtc_pkg::T_SEC] == rtc_pkg::BCD_ZERO))
      else $error("seconds did not wrap to zero");
   chk_leap_2000: assert property (
      sec_tick && !wr_en && (s_q.time_bcd[rtc_pkg::T_YEAR] == 8'h00)
      && (s_q.time_bcd[rtc_pkg::T_MON] == rtc_pkg::MON_FEB)
      && (s_q.time_bcd[rtc_pkg::T_DATE] == rtc_pkg::LAST_28)
      && (s_q.time_bcd[2:0] == 24'h235959)
      |=> (s_q.time_bcd[rtc_pkg::T_DATE] == rtc_pkg::LAST_29))
      else $error("year 00 not treated as leap");
   chk_april_end: assert property (
      sec_tick && !wr_en && (s_q.time_bcd[rtc_pkg::T_MON] == 8'h04)
      && (s_q.time_bcd[rtc_pkg::T_DATE] == rtc_pkg::LAST_30)
      && (s_q.time_bcd[2:0] == 24'h235959)
      |=> (s_q.time_bcd[rtc_pkg::T_DATE] == rtc_pkg::BCD_ONE)
          && (s_q.time_bcd[rtc_pkg::T_MON] == 8'h05))
      else $error("30 day month did not roll over");
   chk_prescale_wrap: assert property (
      xtal_edge && !s_q.clock_control_reg[rtc_pkg::CTRL_CNT_RST]
      && (s_q.pre == rtc_pkg::PRE_LAST) |=> (s_q.pre == 8'h00) && $changed(s_q.sub))
      else $error("prescaler did not wrap at 128 Hz");
   chk_alarm_sts: assert property (
      alm_event |=> s_q.irq_sts[rtc_pkg::IRQ_ALARM]
      && (irq_out || !s_q.irq_mask[rtc_pkg::IRQ_ALARM]))
      else $error("alarm event not latched");
   chk_alarm_cause: assert property (
      alm_event |-> s_q.alarm_control_reg[rtc_pkg::ALM_GLOBAL]
      && (!s_q.alarm_control_reg[rtc_pkg::T_DATE]
          || (s_q.time_bcd[rtc_pkg::T_DATE] == s_q.alm_bcd[rtc_pkg::T_DATE])))
      else $error("alarm without global enable");
   chk_wake_set: assert property (
      alm_event && power_off ##1 power_off |-> power_wakeup_out)
      else $error("wake-up missing in power-off alarm");
   chk_wake_clr: assert property (
      !power_off |=> !power_wakeup_out)
      else $error("wake-up driven in normal mode");
   chk_tick_fire: assert property (
      tick128 && (s_q.tick_cnt == '0) && s_q.tick_control_reg[rtc_pkg::TICK_EN]
      |=> s_q.irq_sts[rtc_pkg::IRQ_TICK])
      else $error("tick interrupt not requested at zero");
   chk_tick_reload: assert property (
      tick128 && !wr_en && (s_q.tick_cnt == '0)
      |=> s_q.tick_cnt == $past(s_q.tick_control_reg[TICK_CNT_HI:0]))
      else $error("tick count not reloaded");
   chk_isolated_read: assert property (
      power_off && rd_en |=> (rdata == 8'h00))
      else $error("register read during power off");

   cov_alarm: cover property (alm_event && !power_off);
   cov_wake: cover property (alm_event && power_off);
   cov_tick: cover property (tick128 && (s_q.tick_cnt == '0)
                             && s_q.tick_control_reg[rtc_pkg::TICK_EN]);
   cov_year_roll: cover property (sec_tick && (s_q.time_bcd[rtc_pkg::T_YEAR] == 8'h99)
                                  && (s_q.time_bcd[rtc_pkg::T_MON] == 8'h12)
                                  && (s_q.time_bcd[rtc_pkg::T_DATE] == 8'h31)
                                  && (s_q.time_bcd[2:0] == 24'h235959));

endmodule : bcd_rtc_alarm_tick

`default_nettype wire

// file: xtal_model.sv
// Purpose: Crystal stand-in feeding xtal_in of the clock block
// Assumes: Sampled synchronously on core_clk, one rising sample per two cycles
// Notes:   Scaled far above 32.768 kHz so a whole second fits the run
`timescale 1ns/1ps
`default_nettype none
module xtal_model
(
   input  wire logic core_clk,
   output var  logic xtal_in
);
   logic osc_q = 1'b0;
   // Free running oscillator, never stops in backup mode
   always @(posedge core_clk) osc_q <= ~osc_q;
   assign xtal_in = osc_q;
endmodule : xtal_model
`default_nettype wire

// file: bcd_rtc_alarm_tick_tb.sv
// Purpose: Self-checking bench for the BCD clock, alarm and tick block
// Assumes: 256 crystal rising samples per tick, crystal edge every 2 cycles
// Notes:   Read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module bcd_rtc_alarm_tick_tb;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        xtal_in;
   logic        power_off = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [7:0]  rdata;
   logic        irq_out;
   logic        power_wakeup_out;
   logic        rd_seen = 1'b0;
   logic [15:0] exp_q[$];
   int          bad_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          t1;
   logic [6:0]  n;
   logic [7:0]  rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   xtal_model u_xtal_model (.core_clk(core_clk), .xtal_in(xtal_in));

   bcd_rtc_alarm_tick u_bcd_rtc_alarm_tick
   (
      .core_clk         (core_clk),
      .resetn           (resetn),
      .xtal_in          (xtal_in),
      .power_off        (power_off),
      .addr             (addr),
      .wdata            (wdata),
      .wr_en            (wr_en),
      .rd_en            (rd_en),
      .rdata            (rdata),
      .irq_out          (irq_out),
      .power_wakeup_out (power_wakeup_out)
   );

   task report_and_stop;
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({a, e});
      @(posedge core_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
   endtask : rd

   task settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle

   // Bounded wait on irq_out (sel 0) or power_wakeup_out (sel 1)
   task wait_for(input int lim, input bit sel);
      int k;
      for (k = 0; k < lim; k++)
      begin
         @(posedge core_clk);
         #1;
         if ((sel ? power_wakeup_out : irq_out) === 1'b1)
            break;
      end
      if (k == lim)
      begin
         bad_count++;
         $display("BAD wait expected 1 seen 0");
         report_and_stop();
      end
   endtask : wait_for

   // Read data stand only in the cycle after the strobe
   always @(posedge core_clk)
   begin
      logic [15:0] e;
      if (rd_seen)
      begin
         e = exp_q.pop_front();
         chk($sformatf("rdata@%h", e[15:8]), e[7:0], rdata);
      end
      rd_seen <= rd_en;
   end

   initial
   begin
      void'($urandom(13));
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(8'h70 + 8'(4 * i), rstv[i]);
      rd(8'h40, 8'h00);
      rd(8'h3c, 8'h00);
      wr(8'h70, 8'h33);
      rd(8'h70, 8'h00);
      wr(8'h40, 8'h01);
      wr(8'h70, 8'hff);
      rd(8'h70, 8'h7f);
      n = 7'(1 + $urandom % 3);
      wr(8'h94, 8'h02);
      wr(8'h44, {1'b1, n});
      rd(8'h44, {1'b1, n});
      wait_for(3000, 1'b0);
      t1 = cyc;
      chk("wake_normal", 0, power_wakeup_out);
      wr(8'h90, 8'h02);
      settle();
      chk("irq_cleared", 0, irq_out);
      wait_for(3000, 1'b0);
      chk("tick_period", (n + 1) * 512, cyc - t1);
      wr(8'h94, 8'h00);
      settle();
      chk("irq_masked", 0, irq_out);
      rd(8'h90, 8'h02);
      wr(8'h44, 8'h00);
      wr(8'h90, 8'h03);
      // One second before the 2000 leap day
      wr(8'h70, 8'h59);
      wr(8'h74, 8'h59);
      wr(8'h78, 8'h23);
      wr(8'h7c, 8'h28);
      wr(8'h84, 8'h02);
      wr(8'h88, 8'h00);
      wr(8'h60, 8'h29);
      wr(8'h50, 8'h48);
      wr(8'h94, 8'h01);
      wr(8'h40, 8'h09);
      wr(8'h40, 8'h00);
      @(posedge core_clk);
      power_off <= 1'b1;
      rd(8'h7c, 8'h00);
      wr(8'h50, 8'h00);
      wait_for(70000, 1'b1);
      chk("irq_alarm", 1, irq_out);
      @(posedge core_clk);
      power_off <= 1'b0;
      settle();
      chk("wake_off", 0, power_wakeup_out);
      // Year down to seconds; seconds read as zero, so the pass is repeated
      repeat (2)
      begin
         rd(8'h88, 8'h00);
         rd(8'h84, 8'h02);
         rd(8'h7c, 8'h29);
         rd(8'h78, 8'h00);
         rd(8'h74, 8'h00);
         rd(8'h70, 8'h00);
      end
      rd(8'h90, 8'h01);
      repeat (3) @(posedge core_clk);
      report_and_stop();
   end
endmodule : bcd_rtc_alarm_tick_tb
`default_nettype wire
